// [test_ufc_rx_flow.sv]
// Self-checking bench for the receive flow control block.
// Inputs change at falling edges; the remote model feeds characters.
`timescale 1ns/10ps
module test_ufc_rx_flow;
  localparam int RX_DEPTH = 16;
  logic clk = 1'b0;
  logic rst_b, rhr_read, sw_fc_enable, sw_fc_double, char_wr, rx_enable, cts_n, tx_pending, slow;
  logic flow_event_clr, char_event_clr, lsr_event_clr, rx_char_valid, rx_char_ready, rx_parity_bit;
  logic rx_parity_err, rx_frame_err, rx_break, rx_data_ready, rx_auto_enabled, rts_n, tx_halt;
  logic flow_tx_valid, flow_tx_ready, isr_flow_event, isr_char_event, lsr_event, int_req;
  logic [1:0] char_sel;
  logic [2:0] line_status_tags;
  logic [7:0] enhanced_feature_reg, extra_feature_ctrl, modem_control_reg, interrupt_enable_reg;
  logic [7:0] halt_resume_level_reg, line_control_reg, char_wr_data, rx_char_data, rx_holding_reg;
  logic [7:0] rx_level, flow_tx_data;
  int failures = 0;
  int samples_checked = 0;
  ufc_rx_flow #(.RX_DEPTH(RX_DEPTH)) i_ufc_rx_flow (.*);
  ufc_remote i_ufc_remote (.*);
  always #50 clk = ~clk;
  task automatic end_sim;
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Send one character, then let it reach the holding register
  task automatic rx(input logic [7:0] d, input logic [3:0] t);
    logic ok;
    i_ufc_remote.send(d, t, ok);
    check("rx_char_ready", 8'h01, {7'h0, ok});
    if (!ok) end_sim;
    repeat (2) @(negedge clk);
  endtask : rx
  task automatic read_rhr;
    rhr_read = 1'b1;
    @(negedge clk);
    rhr_read = 1'b0;
    @(negedge clk);
  endtask : read_rhr
  task automatic clr;
    {flow_event_clr, char_event_clr, lsr_event_clr} = 3'h7;
    @(negedge clk);
    {flow_event_clr, char_event_clr, lsr_event_clr} = 3'h0;
  endtask : clr
  task automatic set_char(input logic [1:0] s, input logic [7:0] v);
    {char_wr, char_sel, char_wr_data} = {1'b1, s, v};
    @(negedge clk);
    char_wr = 1'b0;
  endtask : set_char
  // Special character is stored and flagged
  task automatic t_special(input logic [7:0] v);
    {extra_feature_ctrl, enhanced_feature_reg} = {8'h00, 8'h20};
    clr;
    rx(v, 4'h0);
    check("isr_char_event", 8'h01, isr_char_event);
    check("rx_holding_reg", v, rx_holding_reg);
    read_rhr;
    enhanced_feature_reg = 8'h00;
  endtask : t_special
  // Each character carries its own error tag out
  task automatic t_holding;
    logic [7:0] d [3] = '{8'hA5, 8'h3C, 8'h00};
    for (int i = 0; i < 3; i++) rx(d[i], 4'h4 >> i);
    check("rx_level", 8'h03, rx_level);
    for (int i = 0; i < 3; i++) begin
      check("rx_holding_reg", d[i], rx_holding_reg);
      check("line_status_tags", 8'h01 << i, {5'h0, line_status_tags});
      read_rhr;
    end
    check("rx_data_ready", 8'h00, rx_data_ready);
  endtask : t_holding
  // Fill until refused with the sink stalling, then drain in order
  task automatic t_fill;
    logic ok;
    int n, k;
    {enhanced_feature_reg, modem_control_reg, interrupt_enable_reg} = {8'h50, 8'h02, 8'h40};
    {halt_resume_level_reg, sw_fc_enable, slow} = {8'h12, 1'b1, 1'b1};
    set_char(ufc_pkg::SEL_PAUSE_ONE, 8'h13);
    set_char(ufc_pkg::SEL_RESUME_ONE, 8'h11);
    for (n = 0; n < RX_DEPTH + 4; n++) begin
      i_ufc_remote.send(8'h40 + n[7:0], 4'h0, ok);
      if (!ok) break;
    end
    repeat (4) @(negedge clk);
    check("refused", 8'h00, {7'h0, ok});
    check("accepted", 8'h01, {7'h0, n >= RX_DEPTH});
    check("rts_n", 8'h01, rts_n);
    check("isr_flow_event", 8'h01, isr_flow_event);
    check("flow_tx_data", 8'h13, i_ufc_remote.last_flow);
    for (k = 0; k < n && rx_data_ready === 1'b1; k++) begin
      check("rx_holding_reg", 8'h40 + k[7:0], rx_holding_reg);
      read_rhr;
    end
    repeat (4) @(negedge clk);
    check("drained", n[7:0], k[7:0]);
    check("rts_n", 8'h00, rts_n);
    check("flow_tx_data", 8'h11, i_ufc_remote.last_flow);
    {enhanced_feature_reg, modem_control_reg, sw_fc_enable, slow} = '0;
  endtask : t_fill
  // Narrow word length: upper bits must not spoil the match
  task automatic t_sw;
    {interrupt_enable_reg, sw_fc_enable, line_control_reg} = {8'h20, 1'b1, 8'h00};
    rx(8'hF3, 4'h0);
    check("tx_halt", 8'h01, tx_halt);
    check("int_req", 8'h01, int_req);
    check("rx_data_ready", 8'h00, rx_data_ready);
    rx(8'hD1, 4'h0);
    check("tx_halt", 8'h00, tx_halt);
    check("isr_char_event", 8'h00, isr_char_event);
    check("rx_data_ready", 8'h00, rx_data_ready);
    {sw_fc_enable, line_control_reg} = {1'b0, 8'h03};
  endtask : t_sw
  task automatic t_cts;
    {enhanced_feature_reg, interrupt_enable_reg} = {8'h90, 8'h80};
    clr;
    cts_n = 1'b1;
    repeat (4) @(negedge clk);
    check("tx_halt", 8'h01, tx_halt);
    check("isr_flow_event", 8'h01, isr_flow_event);
    cts_n = 1'b0;
    repeat (4) @(negedge clk);
    check("tx_halt", 8'h00, tx_halt);
    enhanced_feature_reg = 8'h00;
  endtask : t_cts
  task automatic t_dir;
    for (int inv = 0; inv < 2; inv++) begin
      {extra_feature_ctrl, tx_pending} = {inv ? 8'h30 : 8'h10, 1'b0};
      repeat (2) @(negedge clk);
      check("rts_n idle", inv ? 8'h00 : 8'h01, rts_n);
      tx_pending = 1'b1;
      repeat (2) @(negedge clk);
      check("rts_n send", inv ? 8'h01 : 8'h00, rts_n);
    end
    {extra_feature_ctrl, tx_pending} = {8'h00, 1'b0};
  endtask : t_dir
  task automatic t_drop;
    {extra_feature_ctrl, interrupt_enable_reg, rx_enable} = {8'h01, 8'h04, 1'b0};
    clr;
    rx(8'h55, 4'h0);
    check("rx_data_ready", 8'h00, rx_data_ready);
    rx(8'hA1, 4'h8);
    check("rx_holding_reg", 8'hA1, rx_holding_reg);
    check("line_status_tags", 8'h01, {5'h0, line_status_tags});
    check("int_req", 8'h01, int_req);
    rx_enable = 1'b1;
    rx(8'h66, 4'h0);
    check("rx_level", 8'h02, rx_level);
    read_rhr;
    read_rhr;
  endtask : t_drop
  task automatic t_auto;
    set_char(ufc_pkg::SEL_PAUSE_TWO, 8'h42);
    {enhanced_feature_reg, rx_enable} = {8'h20, 1'b0};
    clr;
    rx(8'h55, 4'h8);
    rx(8'h66, 4'h0);
    check("rx_level", 8'h00, rx_level);
    rx(8'h42, 4'h8);
    check("rx_auto_enabled", 8'h01, rx_auto_enabled);
    check("line_status_tags", 8'h01, {5'h0, line_status_tags});
    check("lsr_event", 8'h01, lsr_event);
    rx(8'h77, 4'h0);
    rx(8'h43, 4'h8);
    check("rx_auto_enabled", 8'h00, rx_auto_enabled);
    check("rx_level", 8'h02, rx_level);
    read_rhr;
    read_rhr;
    {extra_feature_ctrl, enhanced_feature_reg} = '0;
  endtask : t_auto
  // Main sequence, with a second reset late in the run
  initial begin
    {rst_b, rhr_read, sw_fc_enable, sw_fc_double, char_wr, rx_enable, cts_n, tx_pending, slow} = '0;
    {flow_event_clr, char_event_clr, lsr_event_clr, char_sel, char_wr_data} = '0;
    {enhanced_feature_reg, extra_feature_ctrl, modem_control_reg, interrupt_enable_reg} = '0;
    {halt_resume_level_reg, line_control_reg} = {8'h00, 8'h03};
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    check("rts_n", 8'h01, rts_n);
    check("rx_char_ready", 8'h01, rx_char_ready);
    t_special(ufc_pkg::CHAR_POWERUP);
    t_holding;
    t_fill;
    t_sw;
    t_cts;
    t_dir;
    t_drop;
    t_auto;
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    t_special(8'h42);
    end_sim;
  end
endmodule : test_ufc_rx_flow

// [ufc_pkg.sv]
// Constants shared by the receive flow control block.
// Assumes one 10 MHz clock and control fields driven as plain ports by the host side.
package ufc_pkg;

  // Enhanced feature field positions
  localparam int EFR_ENH_EN      = 4;
  localparam int EFR_SPECIAL     = 5;
  localparam int EFR_AUTO_RTS    = 6;
  localparam int EFR_AUTO_CTS    = 7;

  // Extra feature field positions
  localparam int EXTRA_FEATURE_CTRL_MULTIDROP  = 0;
  localparam int EXTRA_FEATURE_CTRL_RS485      = 4;
  localparam int EXTRA_FEATURE_CTRL_RS485_INV  = 5;

  // Modem control and interrupt enable positions
  localparam int MCR_RTS         = 1;
  localparam int IER_LSR         = 2;
  localparam int IER_XOFF        = 5;
  localparam int IER_RTS         = 6;
  localparam int IER_CTS         = 7;

  // Error tag layout, presented as line status bits 4:2
  localparam int TAG_PARITY      = 0;
  localparam int TAG_FRAME       = 1;
  localparam int TAG_BREAK       = 2;
  localparam int TAG_W           = 3;
  localparam int CHAR_W          = 8;

  // Halt and resume nibbles are scaled by four entries
  localparam int LEVEL_SHIFT     = 2;
  localparam int LEVEL_W         = 8;

  // Flow character slots
  localparam logic [1:0] SEL_RESUME_ONE = 2'h0;
  localparam logic [1:0] SEL_RESUME_TWO = 2'h1;
  localparam logic [1:0] SEL_PAUSE_ONE  = 2'h2;
  localparam logic [1:0] SEL_PAUSE_TWO  = 2'h3;
  localparam logic [7:0] CHAR_POWERUP   = 8'h00;

  // Word length code 3 is eight bits; each step down drops one bit
  localparam logic [7:0] WL_FULL_MASK   = 8'hFF;
  localparam logic [1:0] WL_MAX_CODE    = 2'h3;

endpackage : ufc_pkg

// [ufc_remote.sv]
// Remote side: serial receiver hand-over and sink for flow characters.
// Drives at falling edges; the sink can stall every other cycle.
`timescale 1ns/10ps
module ufc_remote (
  input  wire logic       clk,
  output logic            rx_char_valid,
  input  wire logic       rx_char_ready,
  output logic      [7:0] rx_char_data,
  output logic            rx_parity_bit,
  output logic            rx_parity_err,
  output logic            rx_frame_err,
  output logic            rx_break,
  input  wire logic       flow_tx_valid,
  input  wire logic [7:0] flow_tx_data,
  output logic            flow_tx_ready,
  input  wire logic       slow
);
  logic [7:0] last_flow = 8'h00;
  initial {rx_char_valid, rx_char_data, rx_parity_bit, rx_parity_err, rx_frame_err, rx_break, flow_tx_ready} = '0;
  // Sink stalls in slow mode so the block must hold its offer
  always @(negedge clk) flow_tx_ready <= slow ? !flow_tx_ready : 1'b1;
  always @(posedge clk) if (flow_tx_valid && flow_tx_ready) last_flow <= flow_tx_data;
  // Offer one character; holds it for up to 40 cycles until the block is ready
  task automatic send(input logic [7:0] d, input logic [3:0] t, output logic ok);
    int n;
    @(negedge clk);
    {rx_char_valid, rx_char_data} = {1'b1, d};
    {rx_parity_bit, rx_parity_err, rx_frame_err, rx_break} = t;
    for (n = 0; n < 40 && !rx_char_ready; n++) @(negedge clk);
    ok = (n < 40);
    @(negedge clk);
    // Stale lines show inverted data so nothing matches by luck
    {rx_char_valid, rx_char_data} = {1'b0, ~d};
    {rx_parity_bit, rx_parity_err, rx_frame_err, rx_break} = ~t;
  endtask : send
endmodule : ufc_remote

// [ufc_rx_flow.sv]
// Receive holding path, FIFO and line flow control of a UART receiver.
// Assumes a receiver that hands over whole characters with their error tags,
// and a transmitter that checks tx_halt only between characters.
// Functional notes
// - Receive FIFO: 64 entries, 11 bits wide
// - Holding read loads next character and tags
// - Auto request enabled by bit6, started by modem bit1
// - Request rising edge sets status bit5 interrupt
// - Request high at halt, low at resume
// - Keep storing characters while request high
// - Clear input high stops transmitter after character
// - Clear deassertion sets status bit5 interrupt
// - Match one or two pause characters, halt
// - Pause sets flag; resume clears it, resumes
// - Flow characters power up zero, survive reset
// - Consumed flow characters never enter FIFO
// - Send pause at halt, resume at resume
// - Special character stored and sets status bit4; with sw_fc_enable and sw_fc_double both set it is stored unflagged
// - Compare only word length bits
// - Direction output idles high, low while sending
// - Extra bit5 inverts direction polarity
// - Normal multidrop: address flagged, data gated
// - Auto address: match enables, stores parity
// - Non-matching address disables receiver, dropped
`timescale 1ns/10ps

// Synchronous FIFO with valid and ready on both sides
module ufc_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 64,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [CNT_W-1:0] count
);
  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr;
    logic [PTR_W-1:0]            rd;
    logic [CNT_W-1:0]            cnt;
  } ufc_fifo_t;

  ufc_fifo_t q, next_q;
  logic      push, pop;

  // Honest full and empty straight from the count
  assign in_ready  = (q.cnt != CNT_W'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];
  assign count     = q.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer wrap is explicit so depth need not be a power of two
  always_comb begin
    next_q = q;
    if (push) begin
      next_q.mem[q.wr] = in_data;
      next_q.wr = (q.wr == PTR_W'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      next_q.rd = (q.rd == PTR_W'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    end
    next_q.cnt = q.cnt + CNT_W'(push) - CNT_W'(pop);
    if (!rst_b) begin
      next_q.wr  = '0;
      next_q.rd  = '0;
      next_q.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= next_q;
  end
endmodule : ufc_fifo

module ufc_rx_flow #(
  parameter int RX_DEPTH = 64
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       rx_char_valid,
  output logic            rx_char_ready,
  input  wire logic [7:0] rx_char_data,
  input  wire logic       rx_parity_bit,
  input  wire logic       rx_parity_err,
  input  wire logic       rx_frame_err,
  input  wire logic       rx_break,
  input  wire logic       rhr_read,
  output logic      [7:0] rx_holding_reg,
  output logic      [2:0] line_status_tags,
  output logic            rx_data_ready,
  output logic      [7:0] rx_level,
  input  wire logic [7:0] enhanced_feature_reg,
  input  wire logic [7:0] extra_feature_ctrl,
  input  wire logic [7:0] modem_control_reg,
  input  wire logic [7:0] interrupt_enable_reg,
  input  wire logic [7:0] halt_resume_level_reg,
  input  wire logic [7:0] line_control_reg,
  input  wire logic       sw_fc_enable,
  input  wire logic       sw_fc_double,
  input  wire logic       char_wr,
  input  wire logic [1:0] char_sel,
  input  wire logic [7:0] char_wr_data,
  input  wire logic       rx_enable,
  output logic            rx_auto_enabled,
  input  wire logic       cts_n,
  output logic            rts_n,
  input  wire logic       tx_pending,
  output logic            tx_halt,
  output logic            flow_tx_valid,
  output logic      [7:0] flow_tx_data,
  input  wire logic       flow_tx_ready,
  output logic            isr_flow_event,
  input  wire logic       flow_event_clr,
  output logic            isr_char_event,
  input  wire logic       char_event_clr,
  output logic            lsr_event,
  input  wire logic       lsr_event_clr,
  output logic            int_req
);
  localparam int ENTRY_W = ufc_pkg::CHAR_W + ufc_pkg::TAG_W;
  localparam int CNT_W   = $clog2(RX_DEPTH + 1);
  localparam int LEVEL_W_L = ufc_pkg::LEVEL_W;

  typedef struct packed {
    logic [3:0][7:0]        chars;      // Resume one, two, pause one, two
    logic                   stg_v;      // Character waiting for filtering
    logic [7:0]             stg_d;
    logic                   stg_p;
    logic [2:0]             stg_t;
    logic                   pend_v;     // First half of a two-character match
    logic                   pend_off;
    logic [7:0]             pend_d;
    logic [2:0]             pend_t;
    logic                   hold_v;
    logic [7:0]             hold_d;
    logic [2:0]             hold_t;
    logic                   cts_m, cts_s, cts_d;
    logic                   rts_off, rts_d;
    logic                   sw_halt, auto_en, dir_on;
    logic                   off_sent;   // Pause characters have gone out
    logic                   inj_v, inj_off, inj_idx;
    logic                   f_flow, f_char, f_lsr;
  } ufc_state_t;

  ufc_state_t             q = '{chars: {4{ufc_pkg::CHAR_POWERUP}}, default: '0};
  ufc_state_t             next_q;
  logic                   f_in_v, f_in_r, f_out_v, f_out_r;
  logic [ENTRY_W-1:0]     f_in_d, f_out_d;
  logic [CNT_W-1:0]       f_cnt;
  logic [7:0]             wl_mask;
  logic [LEVEL_W_L-1:0]   level, halt_lvl, resume_lvl;
  logic                   auto_rts, auto_mode, norm_md, special;
  logic                   m_p1, m_p2, m_r1, m_r2;

  // Receive FIFO of tagged characters
  ufc_fifo #(
    .WIDTH    (ENTRY_W),
    .DEPTH    (RX_DEPTH),
    .CNT_W    (CNT_W)
  ) u_fifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .in_valid (f_in_v),
    .in_ready (f_in_r),
    .in_data  (f_in_d),
    .out_valid(f_out_v),
    .out_ready(f_out_r),
    .out_data (f_out_d),
    .count    (f_cnt)
  );

  // Mode decode and word-length masked comparisons
  assign wl_mask    = ufc_pkg::WL_FULL_MASK >> (ufc_pkg::WL_MAX_CODE - line_control_reg[1:0]);
  assign m_r1       = ((q.stg_d ^ q.chars[ufc_pkg::SEL_RESUME_ONE]) & wl_mask) == '0;
  assign m_r2       = ((q.stg_d ^ q.chars[ufc_pkg::SEL_RESUME_TWO]) & wl_mask) == '0;
  assign m_p1       = ((q.stg_d ^ q.chars[ufc_pkg::SEL_PAUSE_ONE]) & wl_mask) == '0;
  assign m_p2       = ((q.stg_d ^ q.chars[ufc_pkg::SEL_PAUSE_TWO]) & wl_mask) == '0;
  assign norm_md    = extra_feature_ctrl[ufc_pkg::EXTRA_FEATURE_CTRL_MULTIDROP] && !enhanced_feature_reg[ufc_pkg::EFR_SPECIAL];
  assign auto_mode  = extra_feature_ctrl[ufc_pkg::EXTRA_FEATURE_CTRL_MULTIDROP] && enhanced_feature_reg[ufc_pkg::EFR_SPECIAL];
  assign special    = enhanced_feature_reg[ufc_pkg::EFR_SPECIAL] && !extra_feature_ctrl[ufc_pkg::EXTRA_FEATURE_CTRL_MULTIDROP];
  assign auto_rts   = enhanced_feature_reg[ufc_pkg::EFR_AUTO_RTS];

  // Level counts the holding register too; nibbles are scaled by four
  assign level      = LEVEL_W_L'(f_cnt) + LEVEL_W_L'(q.hold_v);
  assign halt_lvl   = LEVEL_W_L'(halt_resume_level_reg[3:0]) << ufc_pkg::LEVEL_SHIFT;
  assign resume_lvl = LEVEL_W_L'(halt_resume_level_reg[7:4]) << ufc_pkg::LEVEL_SHIFT;

  // Receiver stalls only while the one-entry stage is occupied
  assign rx_char_ready = !q.stg_v;
  // Holding register refills when empty or when the host takes it
  assign f_out_r       = !q.hold_v || rhr_read;

  // Outputs straight from state, except int_req, whose line status and character terms are also gated by interrupt_enable_reg
  assign rx_holding_reg   = q.hold_d;
  assign line_status_tags = q.hold_t;
  assign rx_data_ready    = q.hold_v;
  assign rx_level         = level;
  assign rx_auto_enabled  = q.auto_en;
  assign flow_tx_valid    = q.inj_v;
  assign flow_tx_data     = q.chars[{q.inj_off, q.inj_idx}];
  assign isr_flow_event   = q.f_flow;
  assign isr_char_event   = q.f_char;
  assign lsr_event        = q.f_lsr;
  assign int_req          = (q.f_lsr && interrupt_enable_reg[ufc_pkg::IER_LSR])
                          || q.f_flow || (q.f_char && interrupt_enable_reg[ufc_pkg::IER_XOFF]);

  // Transmitter gate: clear-to-send, pause match, direction not yet turned
  assign tx_halt = (enhanced_feature_reg[ufc_pkg::EFR_AUTO_CTS] && q.cts_s)
                 || q.sw_halt
                 || (extra_feature_ctrl[ufc_pkg::EXTRA_FEATURE_CTRL_RS485] && !q.dir_on);

  // Request pin: direction control, auto flow control, or plain software level
  always_comb begin
    if (extra_feature_ctrl[ufc_pkg::EXTRA_FEATURE_CTRL_RS485]) begin
      rts_n = !q.dir_on ^ extra_feature_ctrl[ufc_pkg::EXTRA_FEATURE_CTRL_RS485_INV];
    end else if (auto_rts && modem_control_reg[ufc_pkg::MCR_RTS]) begin
      rts_n = q.rts_off;
    end else begin
      rts_n = !modem_control_reg[ufc_pkg::MCR_RTS];
    end
  end

  // All sequential behaviour of the block
  always_comb begin
    logic                   push_stg, push_pend, drop, xoff, xon;
    logic [2:0]             tags;
    logic                   lsr_hit, char_hit, flow_hit;
    push_stg  = 1'b0;
    push_pend = 1'b0;
    drop      = 1'b0;
    xoff      = 1'b0;
    xon       = 1'b0;
    lsr_hit   = 1'b0;
    char_hit  = 1'b0;
    flow_hit  = 1'b0;
    tags      = q.stg_t;
    next_q    = q;
    // Flow character storage, written by the host, never reset
    if (char_wr) begin
      next_q.chars[char_sel] = char_wr_data;
    end
    // Clear-to-send pin passes two flops before use
    next_q.cts_m = cts_n;
    next_q.cts_s = q.cts_m;
    next_q.cts_d = q.cts_s;
    // Accept a character into the stage
    if (rx_char_valid && !q.stg_v) begin
      next_q.stg_v = 1'b1;
      next_q.stg_d = rx_char_data;
      next_q.stg_p = rx_parity_bit;
      next_q.stg_t = {rx_break, rx_frame_err, rx_parity_err};
    end
    // Filter the staged character once the FIFO has room
    if (q.stg_v && f_in_r) begin
      if (auto_mode) begin
        if (q.stg_p) begin
          if (m_p2) begin
            next_q.auto_en = 1'b1;
            tags[ufc_pkg::TAG_PARITY] = q.stg_p;
            push_stg = 1'b1;
            lsr_hit  = 1'b1;
          end else begin
            next_q.auto_en = 1'b0;
            drop = 1'b1;
          end
        end else begin
          push_stg = q.auto_en;
          drop     = !q.auto_en;
        end
      end else if (norm_md) begin
        if (q.stg_p) begin
          tags[ufc_pkg::TAG_PARITY] = 1'b1;
          push_stg = 1'b1;
          lsr_hit  = 1'b1;
        end else begin
          push_stg = rx_enable;
          drop     = !rx_enable;
        end
      end else if (sw_fc_enable && sw_fc_double) begin
        if (q.pend_v) begin
          if (q.pend_off ? m_p2 : m_r2) begin
            xoff = q.pend_off;
            xon  = !q.pend_off;
            drop = 1'b1;
          end else begin
            push_pend = 1'b1;            // Stage stays and is looked at again
          end
          next_q.pend_v = 1'b0;
        end else if (m_p1 || m_r1) begin
          next_q.pend_v   = 1'b1;
          next_q.pend_off = m_p1;
          next_q.pend_d   = q.stg_d;
          next_q.pend_t   = q.stg_t;
          drop = 1'b1;
        end else begin
          push_stg = 1'b1;
        end
      end else if (sw_fc_enable && (m_p1 || m_r1)) begin
        xoff = m_p1;
        xon  = !m_p1;
        drop = 1'b1;
      end else begin
        push_stg = 1'b1;
        char_hit = special && m_p2;
      end
      if (push_stg || drop) begin
        next_q.stg_v = 1'b0;
      end
    end
    // Pause and resume matches steer the transmitter
    if (xoff) begin
      next_q.sw_halt = 1'b1;
      char_hit = interrupt_enable_reg[ufc_pkg::IER_XOFF];
    end
    if (xon) begin
      next_q.sw_halt = 1'b0;
    end
    // Automatic request flow control; FIFO keeps filling while off
    if (!(auto_rts && modem_control_reg[ufc_pkg::MCR_RTS])) begin
      next_q.rts_off = 1'b0;
    end else if (level >= halt_lvl) begin
      next_q.rts_off = 1'b1;
    end else if (level <= resume_lvl) begin
      next_q.rts_off = 1'b0;
    end
    next_q.rts_d = rts_n;
    // Event flags for the request and clear-to-send edges
    if (enhanced_feature_reg[ufc_pkg::EFR_ENH_EN]) begin
      if (interrupt_enable_reg[ufc_pkg::IER_RTS] && rts_n && !q.rts_d) begin
        flow_hit = 1'b1;
      end
      if (interrupt_enable_reg[ufc_pkg::IER_CTS] && q.cts_s && !q.cts_d) begin
        flow_hit = 1'b1;
      end
    end
    // Send pause characters at halt, resume characters at resume
    if (q.inj_v && flow_tx_ready) begin
      if (sw_fc_double && !q.inj_idx) begin
        next_q.inj_idx = 1'b1;
      end else begin
        next_q.inj_v = 1'b0;
      end
    end else if (!q.inj_v && sw_fc_enable) begin
      if (!q.off_sent && level >= halt_lvl) begin
        next_q.off_sent = 1'b1;
        next_q.inj_v    = 1'b1;
        next_q.inj_off  = 1'b1;
        next_q.inj_idx  = 1'b0;
      end else if (q.off_sent && level <= resume_lvl) begin
        next_q.off_sent = 1'b0;
        next_q.inj_v    = 1'b1;
        next_q.inj_off  = 1'b0;
        next_q.inj_idx  = 1'b0;
      end
    end
    // Direction turns on as soon as data is loaded, off after last stop bit
    next_q.dir_on = extra_feature_ctrl[ufc_pkg::EXTRA_FEATURE_CTRL_RS485] && tx_pending;
    // Holding register reload; tags follow the character at once
    if (f_out_v && f_out_r) begin
      next_q.hold_v = 1'b1;
      next_q.hold_d = f_out_d[ENTRY_W-1 -: ufc_pkg::CHAR_W];
      next_q.hold_t = f_out_d[ufc_pkg::TAG_W-1:0];
    end else if (rhr_read) begin
      next_q.hold_v = 1'b0;
    end
    // Sticky flags: a set in the clearing cycle wins
    next_q.f_flow = flow_hit || (q.f_flow && !flow_event_clr);
    next_q.f_lsr  = lsr_hit || (q.f_lsr && !lsr_event_clr);
    next_q.f_char = char_hit || (q.f_char && !char_event_clr && !xon);
    f_in_v = push_stg || push_pend;
    f_in_d = push_pend ? {q.pend_d, q.pend_t} : {q.stg_d, tags};
    // Reset clears everything but the flow characters, and sets rts_d
    if (!rst_b) begin
      next_q       = '0;
      next_q.chars = q.chars;
      next_q.rts_d = 1'b1;             // Request pin idles high, so no false edge
    end
  end

  always_ff @(posedge clk) begin
    q <= next_q;
  end
endmodule : ufc_rx_flow

// [ufc_rx_flow_asserts.sv]
// Concurrent checks on the receive flow control block.
// Sees only the top ports; bound into every ufc_rx_flow instance.
`timescale 1ns/10ps
module ufc_rx_flow_asserts #(
  parameter int RX_DEPTH = 64
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       rx_char_valid,
  input wire logic       rx_char_ready,
  input wire logic       rhr_read,
  input wire logic       rx_data_ready,
  input wire logic [7:0] rx_level,
  input wire logic [7:0] enhanced_feature_reg,
  input wire logic [7:0] extra_feature_ctrl,
  input wire logic [7:0] modem_control_reg,
  input wire logic [7:0] interrupt_enable_reg,
  input wire logic [7:0] halt_resume_level_reg,
  input wire logic       sw_fc_enable,
  input wire logic       cts_n,
  input wire logic       rts_n,
  input wire logic       tx_pending,
  input wire logic       tx_halt,
  input wire logic       isr_flow_event,
  input wire logic       lsr_event,
  input wire logic       int_req
);
  logic       auto_rts, plain, take;
  logic [7:0] halt_lvl, resume_lvl;
  // Mode decode; nibbles count in steps of four entries
  assign auto_rts = enhanced_feature_reg[6] && modem_control_reg[1] && !extra_feature_ctrl[4];
  assign plain = !extra_feature_ctrl[0] && !sw_fc_enable;
  assign take = rx_char_valid && rx_char_ready;
  assign halt_lvl = {2'h0, halt_resume_level_reg[3:0], 2'h0};
  assign resume_lvl = {2'h0, halt_resume_level_reg[7:4], 2'h0};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_rts_start: assert property (
    !modem_control_reg[1] && !extra_feature_ctrl[4] |-> rts_n) else $error("request active before start");
  a_rts_halt: assert property (
    auto_rts && halt_lvl > resume_lvl && rx_level >= halt_lvl |=> !auto_rts || rts_n) else $error("no halt");
  a_rts_resume: assert property (
    auto_rts && halt_lvl > resume_lvl && rx_level <= resume_lvl |=> !auto_rts || !rts_n) else $error("no resume");
  a_store_count: assert property (
    take && plain && rx_level < RX_DEPTH && !rhr_read ##1 !rhr_read |=> rx_level == $past(rx_level, 2) + 8'h01)
    else $error("character not stored");
  a_read_pop: assert property (
    rhr_read && rx_data_ready && rx_char_ready && !rx_char_valid |=> rx_level == $past(rx_level) - 8'h01)
    else $error("read did not advance");
  a_cts_stop: assert property (
    (enhanced_feature_reg[7] && cts_n)[*5] |-> tx_halt) else $error("transmitter not halted");
  a_dir_idle: assert property (
    (extra_feature_ctrl[4] && !tx_pending)[*2] |-> rts_n == !extra_feature_ctrl[5]) else $error("direction idle");
  a_dir_drive: assert property (
    (extra_feature_ctrl[4] && tx_pending)[*2] |-> rts_n == extra_feature_ctrl[5]) else $error("direction drive");
  a_rts_flag: assert property (
    enhanced_feature_reg[4] && interrupt_enable_reg[6] && auto_rts && $stable(modem_control_reg) && $rose(rts_n)
    |-> ##[0:1] isr_flow_event) else $error("request edge flag missing");
  a_lsr_int: assert property (
    lsr_event && interrupt_enable_reg[2] |-> int_req) else $error("line status interrupt missing");
endmodule : ufc_rx_flow_asserts

bind ufc_rx_flow ufc_rx_flow_asserts #(.RX_DEPTH(RX_DEPTH)) i_ufc_rx_flow_asserts (.*);
